// *** hw/pms_sequencer.sv ***
// Purpose: power-mode sequencer with hv buck protection
// Assumes: analog status inputs synchronous to hclk, ahb-lite slave
// Notes: Function
// Function
// - default to normal mode after power-on
// - standby pin high enters standby
// - standby pin low restarts normal mode
// - core rail on in normal, off standby
// - memory rail normal on, standby configurable
// - aux rail off by default, configurable
// - reset reloads railcfg, volt, occfg, starts hv regulator
// - load settings, enables, pre-regulator, loop
// - pre-regulator por enables hv driver
// - buck good closes driver supply switch
// - rails sequential after input uvlo clear
// - slave skips hv buck start steps
// - master drives sequence gpo to slaves
// - master fault reboots all, slave self
// - over-voltage soft stop, restart after 10ms
// - under-voltage soft stop, restart after 10ms
// - ignore ov/uv during voltage change
// - uv filter also qualifies short
// - negative overcurrent flips low to high
// - overcurrent enables and thresholds configurable
// - dac ramps 0.5 V, holds 1 ms
// - feedback low sets short flag, reboot
// - no short ramps on, then good
// - fault stops, keeps log; alerts peer only from normal mode
`timescale 1ns/1ns
`include "pms_cfg.svh"
`default_nettype none
module pms_sequencer
  import pms_pkg::*;
#(
  parameter int RESTART_CYC = `PMS_RESTART_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic standby_request_pin,
  input wire logic prereg_por,
  input wire logic hv_buck_good,
  input wire logic [2:0] lv_input_uvlo_ok,
  input wire logic fb_over,
  input wire logic fb_under,
  input wire logic peer_fault_in,
  input wire logic negative_overcurrent,
  output logic hv_regulator_en,
  output logic prereg_en,
  output logic hv_loop_en,
  output logic high_voltage_buck_drv_en,
  output logic first_lv_buck_input_switch,
  output logic core_buck_rail_en,
  output logic memory_buck_rail_en,
  output logic auxiliary_buck_rail_en,
  output logic [9:0] dac_code,
  output logic power_good,
  output logic uv_thr_sel,
  output logic short_circuit_flag,
  output logic seq_gpo,
  output logic fault_alert,
  output logic low_side_off,
  output logic high_side_on,
  output logic [31:0] volt_cfg,
  output logic [31:0] oc_cfg
);
  pms_dac_if dif ();
  pms_state_t st_ff;
  logic [31:0] ctrl_ff, railcfg_ff, volt_ff, occfg_ff, fault_ff;
  logic [2:0] rails_ff; // core, mem, aux enables
  logic [1:0] step_ff; // rail being sequenced
  logic [23:0] tmr_ff;
  logic [3:0] filt_ff;
  logic fb_low_q;
  logic wr_ph_ff;
  logic [7:0] wa_ff;
  logic hv_ok_ff, alert_ff, lso_ff, hso_ff;
  logic ovuv;
  logic master;
  logic fault_now;
  // order decode: maps sequence step to rail index
  function automatic logic [1:0] rail_at(input logic [1:0] ord, input logic [1:0] s);
    rail_at = (ord == 2'h1) ? 2'(2 - s) : s;
  endfunction
  assign master = ctrl_ff[`PMS_CTRL_MASTER];
  // hv-stage ov/uv masked during voltage change
  // uv only counts once the start-up short check has handed over
  assign ovuv = !ctrl_ff[`PMS_CTRL_DVC] && (fb_over || (filt_ff == 4'(`PMS_FILT_CYC) && dif.uv_thr_sel));
  assign fault_now = ovuv || dif.short_det || peer_fault_in;
  // shared filter for uv and short detection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      filt_ff <= 4'h0;
    else if (!fb_under)
      filt_ff <= 4'h0;
    else if (filt_ff != 4'(`PMS_FILT_CYC))
      filt_ff <= filt_ff + 4'h1;
  end
  assign fb_low_q = (filt_ff == 4'(`PMS_FILT_CYC));
  pms_dac_ramp u_ramp (
    .hclk(hclk),
    .hresetn(hresetn),
    .fb_low_q(fb_low_q),
    .dif(dif.ramp)
  );
  assign dif.target = volt_ff[9:0] + `PMS_DAC_TARGET_RST - 10'h02f;
  assign dif.start = (st_ff == PMS_ST_HVDRV) && master;
  assign dif.abort = (st_ff == PMS_ST_STOP);
  // main sequence
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= PMS_ST_RESET;
      rails_ff <= 3'h0;
      step_ff <= 2'h0;
      tmr_ff <= 24'h0;
      hv_ok_ff <= 1'b0;
      alert_ff <= 1'b0;
    end
    else
    begin
      case (st_ff)
        PMS_ST_RESET:
          st_ff <= PMS_ST_LOAD; // regulator up, then settings
        PMS_ST_LOAD:
          st_ff <= master ? PMS_ST_PREREG : PMS_ST_RAILS;
        PMS_ST_PREREG:
          if (prereg_por)
            st_ff <= PMS_ST_HVDRV;
        PMS_ST_HVDRV:
          if (hv_buck_good && dif.good)
          begin
            hv_ok_ff <= 1'b1;
            st_ff <= PMS_ST_SWITCH;
          end
          else if (fault_now)
            st_ff <= PMS_ST_STOP;
        PMS_ST_SWITCH:
        begin
          step_ff <= 2'h0;
          st_ff <= PMS_ST_RAILS;
        end
        PMS_ST_RAILS:
          if (fault_now)
            st_ff <= PMS_ST_STOP;
          else if (&lv_input_uvlo_ok)
          begin
            // one rail per step; aux only if selected
            if (rail_at(railcfg_ff[4:3], step_ff) != 2'h2 || railcfg_ff[1])
              rails_ff[rail_at(railcfg_ff[4:3], step_ff)] <= 1'b1;
            if (step_ff == 2'h2)
              st_ff <= PMS_ST_NORMAL;
            else
              step_ff <= step_ff + 2'h1;
          end
        PMS_ST_NORMAL:
          if (fault_now)
          begin
            alert_ff <= 1'b1;
            step_ff <= 2'h0;
            st_ff <= PMS_ST_STOP;
          end
          else if (standby_request_pin)
          begin
            // core off, mem/aux per setting
            rails_ff <= {railcfg_ff[2], railcfg_ff[0], 1'b0};
            st_ff <= PMS_ST_STANDBY;
          end
          else
            rails_ff[2] <= railcfg_ff[1]; // aux follows its normal setting live
        PMS_ST_STANDBY:
          if (!standby_request_pin)
          begin
            step_ff <= 2'h0;
            st_ff <= PMS_ST_RAILS;
          end
        PMS_ST_STOP:
        begin
          // soft stop rails one at a time, then hv buck
          if (rails_ff != 3'h0)
            rails_ff[step_ff] <= 1'b0;
          step_ff <= (step_ff == 2'h2) ? 2'h0 : step_ff + 2'h1;
          if (rails_ff == 3'h0)
          begin
            hv_ok_ff <= 1'b0;
            tmr_ff <= 24'h0;
            st_ff <= PMS_ST_WAIT;
          end
        end
        PMS_ST_WAIT:
          if (tmr_ff == 24'(RESTART_CYC - 1))
          begin
            alert_ff <= 1'b0;
            st_ff <= PMS_ST_RESET; // reboot, fault log kept
          end
          else
            tmr_ff <= tmr_ff + 24'h1;
        default:
          st_ff <= PMS_ST_RESET;
      endcase
    end
  end
  // ahb-lite address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph_ff <= 1'b0;
      wa_ff <= 8'h00;
    end
    else if (hready)
    begin
      wr_ph_ff <= hsel && htrans[1] && hwrite;
      wa_ff <= haddr[7:0];
    end
  end
  // writable registers; state reset reloads railcfg, volt, occfg but keeps ctrl
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ff <= 32'h1;
      railcfg_ff <= `PMS_RAILCFG_RST;
      volt_ff <= `PMS_VOLT_RST;
      occfg_ff <= `PMS_OCCFG_RST;
    end
    else if (st_ff == PMS_ST_RESET)
    begin
      railcfg_ff <= `PMS_RAILCFG_RST;
      volt_ff <= `PMS_VOLT_RST;
      occfg_ff <= `PMS_OCCFG_RST;
    end
    else if (wr_ph_ff)
    begin
      case (wa_ff)
        `PMS_REG_CTRL: ctrl_ff <= {29'h0, hwdata[2:0]};
        `PMS_REG_RAILCFG: railcfg_ff <= {27'h0, hwdata[4:0]};
        `PMS_REG_VOLT: volt_ff <= hwdata;
        `PMS_REG_OCCFG: occfg_ff <= {16'h0, hwdata[15:0]};
        default: ;
      endcase
    end
  end
  // fault log: sticky, hardware set wins over write-1 clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fault_ff <= 32'h0;
    else
      fault_ff <= ((wr_ph_ff && wa_ff == `PMS_REG_FAULT) ? (fault_ff & ~hwdata) : fault_ff)
        | {28'h0, peer_fault_in, dif.short_det, ovuv && fb_low_q && dif.uv_thr_sel, ovuv && fb_over};
  end
  // read data, registered off the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (hready && hsel && htrans[1] && !hwrite)
      case (haddr[7:0])
        `PMS_REG_CTRL: hrdata <= ctrl_ff;
        `PMS_REG_RAILCFG: hrdata <= railcfg_ff;
        `PMS_REG_VOLT: hrdata <= volt_ff;
        `PMS_REG_OCCFG: hrdata <= occfg_ff;
        `PMS_REG_STATUS: hrdata <= {19'h0, rails_ff, st_ff};
        `PMS_REG_FAULT: hrdata <= fault_ff;
        default: hrdata <= 32'h0;
      endcase
  end
  // negative overcurrent handling, gated by its enable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lso_ff <= 1'b0;
      hso_ff <= 1'b0;
    end
    else
    begin
      lso_ff <= negative_overcurrent && occfg_ff[12];
      hso_ff <= negative_overcurrent && occfg_ff[12];
    end
  end
  // registered outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hv_regulator_en <= 1'b0;
      prereg_en <= 1'b0;
      hv_loop_en <= 1'b0;
      high_voltage_buck_drv_en <= 1'b0;
      first_lv_buck_input_switch <= 1'b0;
      core_buck_rail_en <= 1'b0;
      memory_buck_rail_en <= 1'b0;
      auxiliary_buck_rail_en <= 1'b0;
      dac_code <= 10'h0;
      power_good <= 1'b0;
      uv_thr_sel <= 1'b0;
      short_circuit_flag <= 1'b0;
      seq_gpo <= 1'b1;
      fault_alert <= 1'b0;
      low_side_off <= 1'b0;
      high_side_on <= 1'b0;
      volt_cfg <= `PMS_VOLT_RST;
      oc_cfg <= `PMS_OCCFG_RST;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hv_regulator_en <= 1'b1;
      prereg_en <= master && (st_ff != PMS_ST_RESET) && (st_ff != PMS_ST_LOAD) && (st_ff != PMS_ST_WAIT);
      hv_loop_en <= master && (st_ff != PMS_ST_RESET) && (st_ff != PMS_ST_LOAD) && (st_ff != PMS_ST_WAIT);
      high_voltage_buck_drv_en <= master && (st_ff & (PMS_ST_HVDRV | PMS_ST_SWITCH | PMS_ST_RAILS
        | PMS_ST_NORMAL | PMS_ST_STANDBY | PMS_ST_STOP)) != 10'h0;
      first_lv_buck_input_switch <= hv_ok_ff;
      core_buck_rail_en <= rails_ff[0];
      memory_buck_rail_en <= rails_ff[1];
      auxiliary_buck_rail_en <= rails_ff[2];
      dac_code <= dif.dac;
      power_good <= dif.good;
      uv_thr_sel <= dif.uv_thr_sel;
      short_circuit_flag <= fault_ff[2];
      // slaves follow master gpo: high holds them in standby
      seq_gpo <= ctrl_ff[`PMS_CTRL_SEQGPO] && master && (st_ff != PMS_ST_NORMAL);
      fault_alert <= alert_ff;
      low_side_off <= lso_ff;
      high_side_on <= hso_ff;
      volt_cfg <= volt_ff;
      oc_cfg <= occfg_ff;
    end
  end
endmodule
`default_nettype wire

// *** common/pms_cfg.svh ***
// Purpose: constants for the power-mode sequencer
// Assumes: 10 MHz hclk, 32-bit ahb-lite register bus
// Notes: times are kept in their own unit, cycle counts derived from them
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH
`define PMS_CLK_HZ 10000000
`define PMS_RESTART_MS 10
`define PMS_RESTART_CYC ((`PMS_RESTART_MS * `PMS_CLK_HZ) / 1000)
`define PMS_SCP_HOLD_MS 1
`define PMS_SCP_HOLD_CYC ((`PMS_SCP_HOLD_MS * `PMS_CLK_HZ) / 1000)
`define PMS_FILT_CYC 8
`define PMS_STEP_CYC 4
// dac codes in 5 mV steps
`define PMS_DAC_W 10
`define PMS_DAC_SCP_HOLD 10'h064
`define PMS_DAC_TARGET_RST 10'h0c8
// register byte offsets
`define PMS_REG_CTRL 8'h00
`define PMS_REG_RAILCFG 8'h04
`define PMS_REG_VOLT 8'h08
`define PMS_REG_OCCFG 8'h0c
`define PMS_REG_STATUS 8'h10
`define PMS_REG_FAULT 8'h14
// ctrl fields
`define PMS_CTRL_MASTER 0
`define PMS_CTRL_SEQGPO 1
`define PMS_CTRL_DVC 2
// railcfg fields: [0] mem standby keep, [1] aux normal, [2] aux standby, [4:3] order
`define PMS_RAILCFG_RST 32'h00000000
// volt reset: core 1.175 V, mem 1.8 V, aux 3.3 V in 25 mV codes
`define PMS_VOLT_RST 32'h0084482f
`define PMS_OCCFG_RST 32'h00003333
`endif

// *** common/pms_pkg.sv ***
// Purpose: types for the power-mode sequencer
// Assumes: nothing beyond the cfg header
// Notes: one-hot state codes
package pms_pkg;
  typedef enum logic [9:0] {
    PMS_ST_RESET = 10'h001,
    PMS_ST_LOAD = 10'h002,
    PMS_ST_PREREG = 10'h004,
    PMS_ST_HVDRV = 10'h008,
    PMS_ST_SWITCH = 10'h010,
    PMS_ST_RAILS = 10'h020,
    PMS_ST_NORMAL = 10'h040,
    PMS_ST_STANDBY = 10'h080,
    PMS_ST_STOP = 10'h100,
    PMS_ST_WAIT = 10'h200
  } pms_state_t;
  typedef enum logic [4:0] {
    PMS_SC_IDLE = 5'h01,
    PMS_SC_RAMP = 5'h02,
    PMS_SC_HOLD = 5'h04,
    PMS_SC_RISE = 5'h08,
    PMS_SC_GOOD = 5'h10
  } pms_sc_state_t;
endpackage

// *** common/pms_dac_if.sv ***
// Purpose: link between sequencer and dac ramp unit
// Assumes: one clock
// Notes: plain grouped signals
`timescale 1ns/1ns
`default_nettype none
interface pms_dac_if;
  logic start;
  logic abort;
  logic [9:0] target;
  logic [9:0] dac;
  logic good;
  logic short_det;
  logic uv_thr_sel;
  modport seq (output start, output abort, output target, input dac, input good, input short_det, input uv_thr_sel);
  modport ramp (input start, input abort, input target, output dac, output good, output short_det, output uv_thr_sel);
endinterface
`default_nettype wire

// *** hw/pms_dac_ramp.sv ***
// Purpose: reference dac ramp with start-up short check
// Assumes: fb_low is a synchronous comparator level
// Notes: filter shared with under-voltage qualification
`timescale 1ns/1ns
`include "pms_cfg.svh"
`default_nettype none
module pms_dac_ramp
  import pms_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fb_low_q,
  pms_dac_if.ramp dif
);
  pms_sc_state_t st_ff;
  logic [9:0] dac_ff;
  logic [15:0] cnt_ff;
  logic good_ff;
  logic short_ff;
  // ramp and hold sequencing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= PMS_SC_IDLE;
      dac_ff <= 10'h000;
      cnt_ff <= 16'h0000;
      good_ff <= 1'b0;
      short_ff <= 1'b0;
    end
    else if (dif.abort)
    begin
      // forced back to 0 V on any stop
      st_ff <= PMS_SC_IDLE;
      dac_ff <= 10'h000;
      good_ff <= 1'b0;
      short_ff <= 1'b0;
    end
    else
    begin
      case (st_ff)
        PMS_SC_IDLE:
        begin
          if (dif.start)
          begin
            st_ff <= PMS_SC_RAMP;
          end
        end
        PMS_SC_RAMP:
        begin
          // 0 V up to 0.5 V
          if (dac_ff >= `PMS_DAC_SCP_HOLD)
          begin
            st_ff <= PMS_SC_HOLD;
            cnt_ff <= 16'h0000;
          end
          else
          begin
            dac_ff <= dac_ff + 10'h001;
          end
        end
        PMS_SC_HOLD:
        begin
          // hold 1 ms, sample filtered result at end
          if (cnt_ff == 16'(`PMS_SCP_HOLD_CYC - 1))
          begin
            if (fb_low_q)
            begin
              short_ff <= 1'b1;
              dac_ff <= 10'h000;
              st_ff <= PMS_SC_IDLE;
            end
            else
            begin
              st_ff <= PMS_SC_RISE;
            end
          end
          else
          begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        PMS_SC_RISE:
        begin
          if (dac_ff == dif.target)
          begin
            st_ff <= PMS_SC_GOOD;
            good_ff <= 1'b1;
          end
          else if (dac_ff < dif.target)
          begin
            dac_ff <= dac_ff + 10'h001;
          end
          else
          begin
            dac_ff <= dac_ff - 10'h001;
          end
        end
        PMS_SC_GOOD:
        begin
          // track target changes
          dac_ff <= dif.target;
        end
        default:
        begin
          st_ff <= PMS_SC_IDLE;
        end
      endcase
    end
  end
  assign dif.dac = dac_ff;
  assign dif.good = good_ff;
  assign dif.short_det = short_ff;
  // threshold 0.3 V until good, then under-voltage level
  assign dif.uv_thr_sel = good_ff;
endmodule
`default_nettype wire

// *** tb/pms_seq_monitor.sv ***
// Purpose: port-level checker for the power-mode sequencer
// Assumes: single hclk domain, async active-low hresetn
// Notes: bound from the testbench top file
`timescale 1ns/1ns
`default_nettype none
module pms_seq_monitor
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic standby_request_pin,
  input wire logic prereg_por,
  input wire logic hv_buck_good,
  input wire logic [2:0] lv_input_uvlo_ok,
  input wire logic negative_overcurrent,
  input wire logic hv_regulator_en,
  input wire logic prereg_en,
  input wire logic high_voltage_buck_drv_en,
  input wire logic first_lv_buck_input_switch,
  input wire logic core_buck_rail_en,
  input wire logic memory_buck_rail_en,
  input wire logic auxiliary_buck_rail_en,
  input wire logic [9:0] dac_code,
  input wire logic power_good,
  input wire logic uv_thr_sel,
  input wire logic short_circuit_flag,
  input wire logic low_side_off,
  input wire logic high_side_on,
  input wire logic [31:0] oc_cfg
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // enabled n-oc event seen at the pins
  sequence noc_hit;
    $rose(negative_overcurrent) && oc_cfg[12];
  endsequence
  // transistor swap that must follow it
  sequence swap_done;
    low_side_off && high_side_on;
  endsequence
  prereg_order_a: assert property ($rose(prereg_en) |-> hv_regulator_en)
    else $error("pre-regulator enabled before hv regulator");
  drv_after_por_a: assert property ($rose(high_voltage_buck_drv_en) |-> $past(prereg_por))
    else $error("buck driver enabled without pre-regulator por");
  switch_good_a: assert property ($rose(first_lv_buck_input_switch) |-> $past(hv_buck_good))
    else $error("driver supply switched before buck good");
  rail_uvlo_a: assert property ($rose(core_buck_rail_en) |-> $past(&lv_input_uvlo_ok))
    else $error("core rail enabled during input uvlo");
  rail_one_a: assert property ($countones({$rose(core_buck_rail_en), $rose(memory_buck_rail_en),
    $rose(auxiliary_buck_rail_en)}) <= 1)
    else $error("two rails enabled in one cycle");
  standby_core_a: assert property (standby_request_pin [*8] |=> !core_buck_rail_en)
    else $error("core rail on during standby");
  noc_swap_a: assert property (noc_hit |-> ##[1:3] swap_done)
    else $error("negative overcurrent not handled");
  scp_dac_a: assert property ($rose(short_circuit_flag) |-> ##[0:2] dac_code == 10'h000)
    else $error("dac not forced to zero on short");
  good_thr_a: assert property (power_good |-> uv_thr_sel && dac_code != 10'h000)
    else $error("power good with short threshold still selected");
endmodule
`default_nettype wire

// *** tb/pms_plant.sv ***
// Purpose: analog side model answering the sequencer's enables
// Assumes: level status signals, synchronous to hclk
// Notes: slow selects a longer answer delay
`timescale 1ns/1ns
`default_nettype none
module pms_plant
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic prereg_en,
  input wire logic drv_en,
  input wire logic uv_req,
  input wire logic peer_supply,
  output logic prereg_por,
  output logic hv_buck_good,
  output logic [2:0] lv_input_uvlo_ok,
  output logic fb_under
);
  logic [2:0] por_ff; // pre-regulator settling
  logic [4:0] good_ff; // buck output settling
  // supplies follow their enables after a settling delay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      por_ff <= 3'h0;
      good_ff <= 5'h00;
    end
    else
    begin
      por_ff <= {por_ff[1:0], prereg_en};
      good_ff <= {good_ff[3:0], drv_en};
    end
  end
  assign prereg_por = por_ff[2];
  assign hv_buck_good = slow ? good_ff[4] : good_ff[0];
  // lv inputs fed by the local hv buck, or by the master's buck in a slave
  assign lv_input_uvlo_ok = {3{hv_buck_good || peer_supply}};
  assign fb_under = uv_req; // forced low feedback models a short
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: self-checking bench for the power-mode sequencer
// Assumes: restart wait shortened to 50 cycles
// Notes: reads are checked through an expectation queue
`timescale 1ns/1ns
`include "pms_cfg.svh"
`default_nettype none
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, standby_request_pin, fb_over, slow;
  logic negative_overcurrent, uv_req, prereg_por, hv_buck_good, fb_under, hv_regulator_en;
  logic prereg_en, hv_loop_en, high_voltage_buck_drv_en, first_lv_buck_input_switch, power_good;
  logic core_buck_rail_en, memory_buck_rail_en, auxiliary_buck_rail_en, uv_thr_sel, seq_gpo;
  logic short_circuit_flag, fault_alert, low_side_off, high_side_on, rd_dp, peer_fault, slave_sup;
  logic [31:0] haddr, hwdata, hrdata, volt_cfg, oc_cfg, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize, lv_input_uvlo_ok;
  logic [9:0] dac_code;
  wire logic hready;
  logic [31:0] exp_q[$]; // expected read data, oldest first
  int n_errors, n_tests;
  assign hready = hreadyout; // single slave drives the bus ready
  pms_sequencer #(.RESTART_CYC(50)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .standby_request_pin, .prereg_por, .hv_buck_good,
    .lv_input_uvlo_ok, .fb_over, .fb_under, .peer_fault_in(peer_fault), .negative_overcurrent,
    .hv_regulator_en, .prereg_en, .hv_loop_en, .high_voltage_buck_drv_en, .first_lv_buck_input_switch,
    .core_buck_rail_en, .memory_buck_rail_en, .auxiliary_buck_rail_en, .dac_code, .power_good,
    .uv_thr_sel, .short_circuit_flag, .seq_gpo, .fault_alert, .low_side_off, .high_side_on,
    .volt_cfg, .oc_cfg);
  pms_plant plant (.hclk, .hresetn, .slow, .prereg_en, .drv_en(high_voltage_buck_drv_en), .uv_req,
    .peer_supply(slave_sup), .prereg_por, .hv_buck_good, .lv_input_uvlo_ok, .fb_under);
  // 100 ns clock
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
  endfunction
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // bounded wait for hready at a rising edge
  task hs_wait;
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hready !== 1'b1 && i < 16);
    if (hready !== 1'b1)
    begin
      n_errors++;
      $display("ERROR hready exp 1 seen %b", hready);
      complete_run;
    end
  endtask
  // one single-word transfer, address phase then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'b010;
    hs_wait;
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    hs_wait;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // bounded wait: 0 core, 1 memory, 2 short flag
  task wait_on(input int sel, input logic v, input int n);
    int i;
    logic s;
    for (i = 0; i < n; i++)
    begin
      tick(1);
      s = sel == 0 ? core_buck_rail_en : sel == 1 ? memory_buck_rail_en : short_circuit_flag;
      if (s === v)
        return;
    end
    n_errors++;
    $display("ERROR wait%0d exp %b seen timeout", sel, v);
    complete_run;
  endtask
  // read data compared when the data phase completes
  always @(posedge hclk)
  begin
    if (rd_dp && hready)
      chk("hrdata", hrdata, exp_q.pop_front());
    if (hready)
      rd_dp <= hsel && htrans[1] && !hwrite;
  end
  task sby(input logic [2:0] rails);
    @(posedge hclk);
    standby_request_pin <= 1'b1;
    tick(12);
    chk("sby", {core_buck_rail_en, memory_buck_rail_en, auxiliary_buck_rail_en}, rails);
    @(posedge hclk);
    standby_request_pin <= 1'b0;
    wait_on(0, 1'b1, 15000);
  endtask
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, hsize, rd_dp} = '0;
    {standby_request_pin, fb_over, negative_overcurrent, uv_req, slow, peer_fault, slave_sup} = '0;
    n_errors = 0;
    n_tests = 0;
    rnd = 32'h1b29;
    hresetn = 1'b0;
    tick(2);
    hresetn = 1'b1;
    chk("volt", volt_cfg, `PMS_VOLT_RST);
    chk("occfg", oc_cfg, `PMS_OCCFG_RST);
    rd(`PMS_REG_CTRL, 32'h1);
    rd(`PMS_REG_RAILCFG, `PMS_RAILCFG_RST);
    rd(8'h20, 32'h0);
    wait_on(1, 1'b1, 15000);
    chk("rails", {core_buck_rail_en, memory_buck_rail_en, auxiliary_buck_rail_en}, 3'b110);
    @(posedge hclk);
    negative_overcurrent <= 1'b1;
    tick(3);
    chk("noc", {low_side_off, high_side_on}, 2'b11);
    negative_overcurrent <= 1'b0;
    rnd = lfsr(rnd);
    bus(1'b1, `PMS_REG_VOLT, rnd);
    tick(1);
    chk("volt", volt_cfg, rnd);
    rd(`PMS_REG_VOLT, rnd);
    slow <= 1'b1;
    sby(3'b000);
    bus(1'b1, `PMS_REG_RAILCFG, 32'h7);
    tick(4);
    chk("aux", auxiliary_buck_rail_en, 1'b1);
    sby(3'b011);
    bus(1'b1, `PMS_REG_CTRL, 32'h5);
    @(posedge hclk);
    fb_over <= 1'b1;
    tick(30);
    chk("dvc", core_buck_rail_en, 1'b1);
    bus(1'b1, `PMS_REG_CTRL, 32'h3); // master, sequence gpo on, no voltage change
    wait_on(0, 1'b0, 40);
    tick(10);
    chk("hvoff", {hresp, high_voltage_buck_drv_en, hv_loop_en, seq_gpo, fault_alert}, 5'b00011);
    fb_over <= 1'b0;
    wait_on(0, 1'b1, 15000);
    rd(`PMS_REG_FAULT, 32'h1);
    rd(`PMS_REG_RAILCFG, 32'h0);
    bus(1'b1, `PMS_REG_FAULT, 32'h1);
    @(posedge hclk);
    uv_req <= 1'b1;
    wait_on(0, 1'b0, 40);
    wait_on(2, 1'b1, 15000);
    tick(3);
    chk("dac", dac_code, 10'h000);
    uv_req <= 1'b0;
    wait_on(0, 1'b1, 25000);
    chk("pg", power_good, 1'b1);
    rd(`PMS_REG_FAULT, 32'h6);
    tick(2);
    chk("gpo", seq_gpo, 1'b0);
    peer_fault <= 1'b1;
    wait_on(0, 1'b0, 40);
    peer_fault <= 1'b0;
    rd(`PMS_REG_FAULT, 32'he);
    bus(1'b1, `PMS_REG_CTRL, 32'h0);
    slave_sup <= 1'b1;
    wait_on(0, 1'b1, 200);
    chk("slave", {prereg_en, high_voltage_buck_drv_en}, 2'b00);
    complete_run;
  end
endmodule
bind pms_sequencer pms_seq_monitor mon (.hclk, .hresetn, .standby_request_pin, .prereg_por,
  .hv_buck_good, .lv_input_uvlo_ok, .negative_overcurrent, .hv_regulator_en, .prereg_en,
  .high_voltage_buck_drv_en, .first_lv_buck_input_switch, .core_buck_rail_en, .memory_buck_rail_en,
  .auxiliary_buck_rail_en, .dac_code, .power_good, .uv_thr_sel, .short_circuit_flag, .low_side_off,
  .high_side_on, .oc_cfg);
`default_nettype wire
